/* smc_pkg.sv */
// Constants, encodings and mode tables shared by the sleep-mode controller ends.
package smc_pkg;
    localparam int SMC_CLK_PERIOD_NS = 10;
    localparam int SMC_BOD_WAKE_NS = 60000;
    localparam int SMC_BOD_WAKE_CYCLES = (SMC_BOD_WAKE_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
    localparam int SMC_HALT_CYCLES = 4;
    localparam int SMC_STANDBY_WAKE_CYCLES = 6;
    localparam int SMC_STARTUP_CYCLES = 16;
    localparam int SMC_BROWNOUT_SLEEP_DISABLE_UNLOCK_CYCLES = 4;
    localparam int SMC_CNT_W = 16;

    localparam logic [2:0] SMC_MODE_IDLE = 3'h0;
    localparam logic [2:0] SMC_MODE_NOISE = 3'h1;
    localparam logic [2:0] SMC_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SMC_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SMC_MODE_RSVD4 = 3'h4;
    localparam logic [2:0] SMC_MODE_RSVD5 = 3'h5;
    localparam logic [2:0] SMC_MODE_STANDBY = 3'h6;
    localparam logic [2:0] SMC_MODE_EXTSTBY = 3'h7;

    // Clock and oscillator enable vector.
    localparam int SMC_NCK = 7;
    localparam int CK_CORE = 0;
    localparam int CK_FLASH = 1;
    localparam int CK_PERIPH = 2;
    localparam int CK_CONV = 3;
    localparam int CK_ASYNC = 4;
    localparam int CK_MAIN = 5;
    localparam int CK_TOSC = 6;
    localparam logic [SMC_NCK-1:0] SMC_CK_ALL = 7'h7F;

    // Wake source vector.
    localparam int SMC_NSRC = 9;
    localparam int WS_EXT_LEVEL = 0;
    localparam int WS_EXT_EDGE = 1;
    localparam int WS_PIN_CHANGE = 2;
    localparam int WS_TWI_MATCH = 3;
    localparam int WS_TIMER2 = 4;
    localparam int WS_SPM_READY = 5;
    localparam int WS_CONV_DONE = 6;
    localparam int WS_WDT = 7;
    localparam int WS_USART_SOF = 8;
    localparam int WS_OTHER_IO = 1;

    localparam int CCR_BROWNOUT_SLEEP_DISABLE_BIT = 6;
    localparam int CCR_BODSE_BIT = 5;
    localparam logic [7:0] SMC_CCR_RESET = 8'h00;

    // APB register byte offsets of the controller.
    localparam logic [7:0] SMC_OFS_CTRL = 8'h00;
    localparam logic [7:0] SMC_OFS_CMD = 8'h04;
    localparam logic [7:0] SMC_OFS_CCR = 8'h08;
    localparam logic [7:0] SMC_OFS_IRQEN = 8'h0C;
    localparam logic [7:0] SMC_OFS_STATUS = 8'h10;
    localparam logic [31:0] SMC_CTRL_RESET = 32'h0000_0000;
    localparam logic [SMC_NSRC-1:0] SMC_IRQEN_RESET = 9'h000;

    function automatic logic smc_deep(input logic [2:0] m);
        smc_deep = (m == SMC_MODE_PDOWN) || (m == SMC_MODE_PSAVE) ||
                   (m == SMC_MODE_STANDBY) || (m == SMC_MODE_EXTSTBY);
    endfunction : smc_deep

    function automatic logic [SMC_NCK-1:0] smc_clocks(input logic [2:0] m, input logic t2a);
        logic [SMC_NCK-1:0] c;
        c = '0;
        case (m)
            SMC_MODE_IDLE: begin
                c = SMC_CK_ALL;
                c[CK_CORE] = 1'b0;
                c[CK_FLASH] = 1'b0;
                c[CK_TOSC] = t2a;
            end
            SMC_MODE_NOISE: begin
                c[CK_CONV] = 1'b1;
                c[CK_ASYNC] = 1'b1;
                c[CK_MAIN] = 1'b1;
                c[CK_TOSC] = t2a;
            end
            SMC_MODE_PSAVE: begin
                c[CK_ASYNC] = 1'b1;
                c[CK_TOSC] = t2a;
            end
            SMC_MODE_STANDBY: begin
                c[CK_MAIN] = 1'b1;
            end
            SMC_MODE_EXTSTBY: begin
                c[CK_ASYNC] = t2a;
                c[CK_MAIN] = 1'b1;
                c[CK_TOSC] = t2a;
            end
            SMC_MODE_PDOWN: begin
                c = '0;
            end
            default: begin
                c = SMC_CK_ALL;
            end
        endcase
        smc_clocks = c;
    endfunction : smc_clocks

    function automatic logic [SMC_NSRC-1:0] smc_wake_mask(input logic [2:0] m, input logic t2a);
        logic [SMC_NSRC-1:0] w;
        w = '0;
        if (m == SMC_MODE_IDLE) begin
            w = '1;
        end else if (m != SMC_MODE_RSVD4 && m != SMC_MODE_RSVD5) begin
            w[WS_EXT_LEVEL] = 1'b1;
            w[WS_PIN_CHANGE] = 1'b1;
            w[WS_TWI_MATCH] = 1'b1;
            w[WS_WDT] = 1'b1;
            w[WS_USART_SOF] = 1'b1;
            w[WS_TIMER2] = (m == SMC_MODE_PSAVE) || (m == SMC_MODE_EXTSTBY) || ((m == SMC_MODE_NOISE) && t2a);
            w[WS_SPM_READY] = (m == SMC_MODE_NOISE);
            w[WS_CONV_DONE] = (m == SMC_MODE_NOISE);
        end
        smc_wake_mask = w;
    endfunction : smc_wake_mask
endpackage : smc_pkg

/* smc_if.sv */
// Link between the core-side sleep command end and the sleep-mode controller.
`timescale 1ns/1ps
interface smc_if;
    logic sleep_req;
    logic sleep_enable;
    logic [2:0] sleep_mode_select;
    logic ccr_wr;
    logic [7:0] ccr_wdata;
    logic [8:0] irq_en;
    logic core_halted;
    logic sleeping;
    logic resume_pulse;
    logic reset_restart;
    logic [7:0] ccr_value;

    modport dev (
        input sleep_req, sleep_enable, sleep_mode_select, ccr_wr, ccr_wdata, irq_en,
        output core_halted, sleeping, resume_pulse, reset_restart, ccr_value
    );
    modport core (
        output sleep_req, sleep_enable, sleep_mode_select, ccr_wr, ccr_wdata, irq_en,
        input core_halted, sleeping, resume_pulse, reset_restart, ccr_value
    );
endinterface : smc_if

/* smc_dev.sv */
// Sleep-mode controller: clock gating, wake-up sequencing and brown-out sleep disable.
//
// Notes on behaviour
// - Sleep needs enable bit plus sleep instruction.
// - Mode 000 Idle stops core and flash.
// - Mode 001 also stops peripheral clock.
// - Interrupt wake: start-up plus four halt cycles.
// - Registers and SRAM kept across sleep.
// - Reset during sleep restarts at reset vector.
// - Deep modes may switch detector off.
// - Detector re-enabled on every wake-up.
// - Detector off adds 60 us wake delay.
// - Disable bit is bit 6, resets zero.
// - Disable bit changes only via timed sequence.
// - Idle wakes on any enabled interrupt.
// - Idle or noise entry starts a conversion.
// - Noise mode wakes on listed sources only.
// - Timer-2 and its oscillator need async clocking; Timer-2 wake in power-save and extended standby is armed without it.
// - Deep modes: serial wakes by start-frame only.
// - Software may power comparator off in Idle.
// - Standby only with crystal main clock.
// - Codes 010, 011, 110, 111 are deeper modes.
// - Standby modes wake in six cycles.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module smc_dev #(
    parameter int BOD_CYCLES = smc_pkg::SMC_BOD_WAKE_CYCLES,
    parameter int STARTUP_CYCLES = smc_pkg::SMC_STARTUP_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Core side.
    smc_if.dev lnk,
    // Wake and reset events from the chip, asynchronous.
    input wire logic [smc_pkg::SMC_NSRC-1:0] wake_src,
    input wire logic reset_event,
    // Same-clock configuration.
    input wire logic timer2_async,
    input wire logic conv_enabled,
    // Clock domain and analog enables.
    output logic [smc_pkg::SMC_NCK-1:0] clock_en,
    output logic brownout_en,
    output logic conv_start
);
    import smc_pkg::*;

    typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_START, ST_BODW, ST_HALT} smc_state_t;

    smc_state_t state;
    logic [SMC_CNT_W-1:0] cnt;
    logic [2:0] mode_q;
    logic bod_off;
    logic from_reset;
    logic [SMC_NSRC-1:0] wake_meta;
    logic [SMC_NSRC-1:0] wake_sync;
    logic rst_meta;
    logic rst_sync;
    logic [7:0] ccr;
    logic [2:0] unlock_cnt;
    logic sleep_go;
    logic wake_hit;

    // Events come from other clock domains and pass two flops first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_meta <= '0;
            wake_sync <= '0;
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            wake_meta <= wake_src;
            wake_sync <= wake_meta;
            rst_meta <= reset_event;
            rst_sync <= rst_meta;
        end
    end

    assign sleep_go = (state == ST_RUN) && lnk.sleep_req && lnk.sleep_enable &&
                      (lnk.sleep_mode_select != SMC_MODE_RSVD4) &&
                      (lnk.sleep_mode_select != SMC_MODE_RSVD5);
    // Mask per mode covers Idle, noise-reduction limits and start-frame-only serial wake.
    assign wake_hit = |(wake_sync & lnk.irq_en & smc_wake_mask(mode_q, timer2_async));

    // Timed write of the disable bit: an unlock write opens a short window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccr <= SMC_CCR_RESET;
            unlock_cnt <= '0;
        end else if (lnk.ccr_wr && lnk.ccr_wdata[CCR_BROWNOUT_SLEEP_DISABLE_BIT] && lnk.ccr_wdata[CCR_BODSE_BIT]) begin
            unlock_cnt <= 3'(SMC_BROWNOUT_SLEEP_DISABLE_UNLOCK_CYCLES);
        end else if (lnk.ccr_wr && !lnk.ccr_wdata[CCR_BODSE_BIT] && unlock_cnt != 3'h0) begin
            ccr[CCR_BROWNOUT_SLEEP_DISABLE_BIT] <= lnk.ccr_wdata[CCR_BROWNOUT_SLEEP_DISABLE_BIT];
            unlock_cnt <= '0;
        end else if (unlock_cnt != 3'h0) begin
            unlock_cnt <= unlock_cnt - 3'h1;
        end
    end

    // Sleep sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;
            cnt <= '0;
            mode_q <= SMC_MODE_IDLE;
            bod_off <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (sleep_go) begin
                        state <= ST_SLEEP;
                        mode_q <= lnk.sleep_mode_select;
                        bod_off <= ccr[CCR_BROWNOUT_SLEEP_DISABLE_BIT] && smc_deep(lnk.sleep_mode_select);
                    end
                end
                ST_SLEEP: begin
                    if (rst_sync || wake_hit) begin
                        state <= ST_START;
                        if (mode_q == SMC_MODE_STANDBY || mode_q == SMC_MODE_EXTSTBY) begin
                            cnt <= SMC_CNT_W'(SMC_STANDBY_WAKE_CYCLES);
                        end else begin
                            cnt <= SMC_CNT_W'(STARTUP_CYCLES);
                        end
                    end
                end
                ST_START: begin
                    if (cnt <= SMC_CNT_W'(1)) begin
                        if (bod_off) begin
                            state <= ST_BODW;
                            cnt <= SMC_CNT_W'(BOD_CYCLES);
                        end else begin
                            state <= ST_HALT;
                            cnt <= SMC_CNT_W'(SMC_HALT_CYCLES);
                        end
                    end else begin
                        cnt <= cnt - SMC_CNT_W'(1);
                    end
                end
                ST_BODW: begin
                    if (cnt <= SMC_CNT_W'(1)) begin
                        state <= ST_HALT;
                        cnt <= SMC_CNT_W'(SMC_HALT_CYCLES);
                        bod_off <= 1'b0;
                    end else begin
                        cnt <= cnt - SMC_CNT_W'(1);
                    end
                end
                ST_HALT: begin
                    if (from_reset || cnt <= SMC_CNT_W'(1)) begin
                        state <= ST_RUN;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt - SMC_CNT_W'(1);
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // A reset seen in the wake path before the last halt cycle wins over the interrupt resume.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            from_reset <= 1'b0;
        end else if (state == ST_RUN) begin
            from_reset <= 1'b0;
        end else if (rst_sync) begin
            from_reset <= 1'b1;
        end
    end

    // Exit pulses to the core.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk.resume_pulse <= 1'b0;
            lnk.reset_restart <= 1'b0;
        end else begin
            lnk.resume_pulse <= (state == ST_HALT) && !from_reset && (cnt <= SMC_CNT_W'(1));
            lnk.reset_restart <= (state == ST_HALT) && from_reset;
        end
    end

    // Gating only stops clocks; nothing here clears core state, so its contents survive sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_en <= SMC_CK_ALL;
            lnk.core_halted <= 1'b0;
            lnk.sleeping <= 1'b0;
        end else begin
            if (sleep_go) begin
                clock_en <= smc_clocks(lnk.sleep_mode_select, timer2_async);
            end else if (state == ST_SLEEP && (rst_sync || wake_hit)) begin
                clock_en <= SMC_CK_ALL & ~(SMC_NCK'(1) << CK_CORE);
            end else if (state == ST_HALT && (from_reset || cnt <= SMC_CNT_W'(1))) begin
                clock_en <= SMC_CK_ALL;
            end else if (state == ST_SLEEP) begin
                clock_en <= smc_clocks(mode_q, timer2_async);
            end
            lnk.core_halted <= sleep_go || (state != ST_RUN &&
                               !(state == ST_HALT && (from_reset || cnt <= SMC_CNT_W'(1))));
            lnk.sleeping <= sleep_go || (state == ST_SLEEP && !(rst_sync || wake_hit));
        end
    end

    // Detector is off only from sleep entry to wake-up; the conversion kicks off at entry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_en <= 1'b1;
            conv_start <= 1'b0;
        end else begin
            if (sleep_go) begin
                brownout_en <= !(ccr[CCR_BROWNOUT_SLEEP_DISABLE_BIT] && smc_deep(lnk.sleep_mode_select));
            end else if (state != ST_SLEEP || rst_sync || wake_hit) begin
                brownout_en <= 1'b1;
            end
            conv_start <= sleep_go && conv_enabled &&
                          (lnk.sleep_mode_select == SMC_MODE_IDLE || lnk.sleep_mode_select == SMC_MODE_NOISE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk.ccr_value <= SMC_CCR_RESET;
        end else begin
            lnk.ccr_value <= ccr;
        end
    end
endmodule : smc_dev

/* smc_core.sv */
// Core-side end: APB registers that issue sleep commands and the timed disable-bit writes.
`timescale 1ns/1ps
module smc_core (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Board configuration, same clock.
    input wire logic crystal_selected,
    // Analog comparator control.
    output logic comparator_power_off,
    // Controller link.
    smc_if.core lnk
);
    import smc_pkg::*;

    logic [31:0] ctrl;
    logic wr_go;
    logic refused;

    assign wr_go = psel && penable && pready && pwrite;

    // One wait-free access: data is prepared in setup, taken in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            case (paddr)
                SMC_OFS_CTRL: prdata <= ctrl;
                SMC_OFS_CCR: prdata <= {24'h000000, lnk.ccr_value};
                SMC_OFS_IRQEN: prdata <= {23'h000000, lnk.irq_en};
                SMC_OFS_STATUS: prdata <= {28'h0000000, refused, lnk.sleeping, lnk.core_halted, !lnk.core_halted};
                default: prdata <= 32'h0000_0000;
            endcase
        end else begin
            pready <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= SMC_CTRL_RESET;
            lnk.irq_en <= SMC_IRQEN_RESET;
        end else if (wr_go && paddr == SMC_OFS_CTRL) begin
            ctrl <= {27'h0000000, pwdata[4:0]};
        end else if (wr_go && paddr == SMC_OFS_IRQEN) begin
            lnk.irq_en <= pwdata[SMC_NSRC-1:0];
        end
    end

    // Standby codes without a crystal are refused; that would leave no clean oscillator restart.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk.sleep_req <= 1'b0;
            lnk.sleep_enable <= 1'b0;
            lnk.sleep_mode_select <= SMC_MODE_IDLE;
            refused <= 1'b0;
            comparator_power_off <= 1'b0;
        end else begin
            lnk.sleep_enable <= ctrl[0];
            lnk.sleep_mode_select <= ctrl[3:1];
            comparator_power_off <= ctrl[4];
            if (wr_go && paddr == SMC_OFS_CMD && pwdata[0]) begin
                refused <= ctrl[3:2] == 2'h3 && !crystal_selected;
                lnk.sleep_req <= !(ctrl[3:2] == 2'h3 && !crystal_selected);
            end else begin
                lnk.sleep_req <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk.ccr_wr <= 1'b0;
            lnk.ccr_wdata <= SMC_CCR_RESET;
        end else begin
            lnk.ccr_wr <= wr_go && paddr == SMC_OFS_CCR;
            lnk.ccr_wdata <= pwdata[7:0];
        end
    end
endmodule : smc_core

/* smc_checker.sv */
// Concurrent checks on the sleep link, the clock enables and the detector enable.
`timescale 1ns/1ps
module smc_checker #(
    parameter int BOD_CYCLES = 20
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link signals.
    input wire logic sleep_req,
    input wire logic sleep_enable,
    input wire logic [2:0] sleep_mode_select,
    input wire logic [7:0] ccr_value,
    input wire logic core_halted,
    input wire logic sleeping,
    input wire logic resume_pulse,
    input wire logic reset_restart,
    // Controller outputs.
    input wire logic [6:0] clock_en,
    input wire logic brownout_en,
    input wire logic conv_start
);
    logic [15:0] since_bod;
    logic bod_was_off;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // A counter stands in for a long repetition, which the tools would unroll.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_bod <= 16'h0000;
        end else if (!brownout_en) begin
            since_bod <= 16'h0000;
        end else if (since_bod != 16'hFFFF) begin
            since_bod <= since_bod + 16'h0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bod_was_off <= 1'b0;
        end else if (!brownout_en) begin
            bod_was_off <= 1'b1;
        end else if (resume_pulse || reset_restart) begin
            bod_was_off <= 1'b0;
        end
    end
    sleep_entry_a: assert property (sleep_req && sleep_enable && !sleep_mode_select[2] && !sleeping && !core_halted
        |=> sleeping && core_halted) else $error("sleep command not taken");
    no_enable_a: assert property (sleep_req && !sleep_enable && !sleeping |=> !sleeping)
        else $error("sleep entered without enable");
    reserved_code_a: assert property (sleep_req && sleep_mode_select[2:1] == 2'b10 && !sleeping
        |=> !sleeping && clock_en == 7'h7F) else $error("reserved code acted on");
    idle_clocks_a: assert property ($rose(sleeping) && sleep_mode_select == 3'h0 |-> clock_en[5:0] == 6'h3C)
        else $error("idle clock set wrong");
    noise_clocks_a: assert property ($rose(sleeping) && sleep_mode_select == 3'h1 |-> clock_en[5:0] == 6'h38)
        else $error("noise clock set wrong");
    halt_four_a: assert property (resume_pulse |-> !core_halted && $past(core_halted) && $past(core_halted, 4))
        else $error("halt before resume too short");
    bod_off_a: assert property ($rose(sleeping) |-> brownout_en == !(ccr_value[6] && sleep_mode_select[1]))
        else $error("detector state at entry wrong");
    bod_back_a: assert property (resume_pulse || reset_restart |-> brownout_en)
        else $error("detector not restored");
    bod_delay_a: assert property (resume_pulse && bod_was_off |-> since_bod >= 16'(BOD_CYCLES + 4))
        else $error("resume too soon after detector restart");
    conv_entry_a: assert property (conv_start |-> $rose(sleeping) && sleep_mode_select[2:1] == 2'b00)
        else $error("conversion start outside idle or noise entry");
endmodule : smc_checker

/* tb_sleep_mode_controller.sv */
// Self-checking bench joining the command end and the controller through their link.
`timescale 1ns/1ps
module tb_sleep_mode_controller;
    import smc_pkg::*;
    localparam int LIMIT = 400;
    localparam int BOD_SIM = 20;
    localparam logic [6:0] EXP_CK [8] = '{7'h3C, 7'h38, 7'h00, 7'h10, 7'h7F, 7'h7F, 7'h20, 7'h20};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_event, brownout_en, conv_start;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] wake_src;
    logic [6:0] clock_en;
    logic xtal, cmp_off;
    int fails = 0, total_checks = 0, resumes = 0, convs = 0, n = 0;
    smc_if lnk();
    smc_core smc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_selected(xtal), .comparator_power_off(cmp_off), .lnk(lnk));
    smc_dev #(.BOD_CYCLES(BOD_SIM), .STARTUP_CYCLES(3)) smc_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk),
        .wake_src(wake_src), .reset_event(reset_event), .timer2_async(1'b0), .conv_enabled(1'b1),
        .clock_en(clock_en), .brownout_en(brownout_en), .conv_start(conv_start));
    smc_checker #(.BOD_CYCLES(BOD_SIM)) smc_checker_inst (.pclk(pclk), .presetn(presetn),
        .sleep_req(lnk.sleep_req), .sleep_enable(lnk.sleep_enable), .sleep_mode_select(lnk.sleep_mode_select),
        .ccr_value(lnk.ccr_value), .core_halted(lnk.core_halted), .sleeping(lnk.sleeping),
        .resume_pulse(lnk.resume_pulse), .reset_restart(lnk.reset_restart), .clock_en(clock_en),
        .brownout_en(brownout_en), .conv_start(conv_start));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (lnk.resume_pulse === 1'b1) resumes++;
        if (conv_start === 1'b1) convs++;
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task test_done;
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // Keep holds psel high so a second setup follows at once, as the unlock window is short.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input bit keep);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < LIMIT);
        chk("pready", 32'(pready), 32'h1);
        if (pready !== 1'b1) test_done();
        rd = prdata;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb
    function automatic logic sig(input int s);
        return (s == 0) ? lnk.sleeping : ((s == 1) ? lnk.resume_pulse : lnk.reset_restart);
    endfunction : sig
    task waitsig(input int s, input string nm);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sig(s) !== 1'b1 && n < LIMIT);
        chk(nm, 32'(sig(s)), 32'h1);
        if (sig(s) !== 1'b1) test_done();
    endtask : waitsig
    task go_sleep(input logic [2:0] m);
        apb(1'b1, SMC_OFS_CTRL, 32'({m, 1'b1}), 1'b1);
        apb(1'b1, SMC_OFS_CMD, 32'h0000_0001, 1'b0);
        repeat (4) @(posedge pclk);
    endtask : go_sleep
    task wake(input int b);
        wake_src[b] <= 1'b1;
        waitsig(1, "resume");
        wake_src[b] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : wake
    task t_reset;
        chk("clock_en reset", 32'(clock_en), 32'h7F);
        chk("ccr reset", 32'(lnk.ccr_value), 32'h0);
        apb(1'b0, 8'h14, 32'h0, 1'b0);
        chk("unmapped read", rd, 32'h0);
        apb(1'b1, SMC_OFS_IRQEN, 32'h0000_01FF, 1'b0);
        $display("Test reset done");
    endtask : t_reset
    task t_refuse;
        apb(1'b1, SMC_OFS_CTRL, 32'h10, 1'b1);
        apb(1'b1, SMC_OFS_CMD, 32'h1, 1'b0);
        repeat (4) @(posedge pclk);
        chk("no enable", 32'(lnk.sleeping), 32'h0);
        chk("comparator off", 32'(cmp_off), 32'h1);
        for (int m = 4; m < 6; m++) begin
            go_sleep(3'(m));
            chk("reserved sleeping", 32'(lnk.sleeping), 32'h0);
            chk("reserved clocks", 32'(clock_en), 32'h7F);
        end
        xtal <= 1'b0;
        go_sleep(SMC_MODE_STANDBY);
        chk("standby refused", 32'(lnk.sleeping), 32'h0);
        apb(1'b0, SMC_OFS_STATUS, 32'h0, 1'b0);
        chk("status", rd, 32'h9);
        xtal <= 1'b1;
        $display("Test refuse done");
    endtask : t_refuse
    task t_modes;
        int c;
        int w;
        for (int m = 0; m < 8; m++) begin
            if (m == 4 || m == 5) continue;
            c = convs;
            go_sleep(3'(m));
            chk("sleeping", 32'(lnk.sleeping), 32'h1);
            chk("mode clocks", 32'(clock_en), 32'(EXP_CK[m]));
            chk("conv start", 32'(convs - c), (m < 2) ? 32'h1 : 32'h0);
            chk("bod kept", 32'(brownout_en), 32'h1);
            wake(WS_PIN_CHANGE);
            w = ((m > 5) ? SMC_STANDBY_WAKE_CYCLES : 3) + SMC_HALT_CYCLES + 4;
            chk("wake cycles", 32'(n), 32'(w));
            chk("clocks awake", 32'(clock_en), 32'h7F);
        end
        $display("Test modes done");
    endtask : t_modes
    task t_noise;
        go_sleep(SMC_MODE_NOISE);
        wake_src[WS_EXT_EDGE] <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("noise filter", 32'(lnk.sleeping), 32'h1);
        wake_src[WS_EXT_EDGE] <= 1'b0;
        @(posedge pclk);
        wake(WS_CONV_DONE);
        go_sleep(SMC_MODE_IDLE);
        wake(WS_EXT_EDGE);
        $display("Test noise done");
    endtask : t_noise
    task t_bod;
        apb(1'b1, SMC_OFS_CCR, 32'h40, 1'b0);
        repeat (3) @(posedge pclk);
        chk("ccr locked", 32'(lnk.ccr_value), 32'h0);
        apb(1'b1, SMC_OFS_CCR, 32'h60, 1'b1);
        apb(1'b1, SMC_OFS_CCR, 32'h40, 1'b0);
        repeat (3) @(posedge pclk);
        chk("ccr unlocked", 32'(lnk.ccr_value), 32'h40);
        go_sleep(SMC_MODE_IDLE);
        chk("bod idle", 32'(brownout_en), 32'h1);
        wake(WS_PIN_CHANGE);
        go_sleep(SMC_MODE_PDOWN);
        chk("bod deep", 32'(brownout_en), 32'h0);
        wake(WS_PIN_CHANGE);
        chk("bod delay", 32'(n > BOD_SIM + 4), 32'h1);
        chk("bod restored", 32'(brownout_en), 32'h1);
        $display("Test detector done");
    endtask : t_bod
    task t_reset_wake;
        int r;
        go_sleep(SMC_MODE_PSAVE);
        r = resumes;
        reset_event <= 1'b1;
        waitsig(2, "reset restart");
        reset_event <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("no resume", 32'(resumes - r), 32'h0);
        chk("bod after reset", 32'(brownout_en), 32'h1);
        $display("Test reset wake done");
    endtask : t_reset_wake
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_src = 9'h000;
        reset_event = 1'b0;
        xtal = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_refuse();
        t_modes();
        t_noise();
        t_bod();
        t_reset_wake();
        test_done();
    end
endmodule : tb_sleep_mode_controller
